// >>> hdl/smac_consts.vh
// Purpose: shared constants of the register access checker
// Assumes: 8-bit register addresses, 8-bit register data
// Notes:   address windows of the four register groups are fixed here
`ifndef SMAC_CONSTS_VH
`define SMAC_CONSTS_VH

// cpu privilege modes
`define SMAC_MODE_W 3
`define SMAC_MODE_BOOT 3'h0
`define SMAC_MODE_TEST 3'h1
`define SMAC_MODE_LEGACY 3'h2
`define SMAC_MODE_SYSTEM 3'h3
`define SMAC_MODE_USER 3'h4

// register groups
`define SMAC_GRP_W 3
`define SMAC_GRP_NONE 3'h0
`define SMAC_GRP_CPU 3'h1
`define SMAC_GRP_SEGCFG 3'h2
`define SMAC_GRP_SYSMGMT 3'h3
`define SMAC_GRP_HW 3'h4

// group address windows (inclusive)
`define SMAC_CPU_LO 8'h80
`define SMAC_CPU_HI 8'h9F
`define SMAC_SEGCFG_LO 8'hA0
`define SMAC_SEGCFG_HI 8'hA7
`define SMAC_SYSMGMT_LO 8'hA8
`define SMAC_SYSMGMT_HI 8'hBF
`define SMAC_HW_LO 8'hC0

// individual registers
`define SMAC_ADDR_PSW_UPPER 8'hA8
`define SMAC_ADDR_PROT_A 8'hA9
`define SMAC_ADDR_PROT_B 8'hAA
`define SMAC_ADDR_PROT_C 8'hAB
`define SMAC_ADDR_RANDOM_OUT 8'hC0
`define SMAC_ADDR_SEG_BASE_LO 8'hA0
`define SMAC_ADDR_SEG_BASE_HI 8'hA1
`define SMAC_ADDR_VIOL_STATUS 8'h9E
`define SMAC_ADDR_VIOL_ADDR 8'h9F

// reset values
`define SMAC_SEG_BASE_RST 8'h00
`define SMAC_VIOL_RST 8'h00

// violation status fields
`define SMAC_VIOL_WR_BIT 0
`define SMAC_VIOL_RD_BIT 1

`endif

// >>> hdl/smac_group_decode.v
// Purpose: classify a register address into its group and flag special registers
// Assumes: purely combinational, same clock domain as the caller
// Notes:   addresses below the cpu window belong to no group
`default_nettype none
`include "smac_consts.vh"

module smac_group_decode (
    input wire [7:0] addr_i,
    output reg [`SMAC_GRP_W-1:0] group_o,
    output wire is_psw_upper_o,
    output wire is_protected_o,
    output wire is_random_out_o
);

    always @* begin
        if (addr_i >= `SMAC_HW_LO) begin
            group_o = `SMAC_GRP_HW;
        end else if (addr_i >= `SMAC_SYSMGMT_LO) begin
            group_o = `SMAC_GRP_SYSMGMT;
        end else if (addr_i >= `SMAC_SEGCFG_LO) begin
            group_o = `SMAC_GRP_SEGCFG;
        end else if (addr_i >= `SMAC_CPU_LO) begin
            group_o = `SMAC_GRP_CPU;
        end else begin
            group_o = `SMAC_GRP_NONE;
        end
    end

    assign is_psw_upper_o = (addr_i == `SMAC_ADDR_PSW_UPPER);
    assign is_protected_o = (addr_i == `SMAC_ADDR_PROT_A) || (addr_i == `SMAC_ADDR_PROT_B) ||
                            (addr_i == `SMAC_ADDR_PROT_C);
    assign is_random_out_o = (addr_i == `SMAC_ADDR_RANDOM_OUT);

endmodule // smac_group_decode
`default_nettype wire

// >>> hdl/smac_rule_eval.v
// Purpose: decide read and write permission from mode, group and segment rights
// Assumes: segment rights come from the descriptor of the code now executing
// Notes:   combinational; an unknown mode keeps only the cpu group open
`default_nettype none
`include "smac_consts.vh"

module smac_rule_eval (
    input wire [`SMAC_MODE_W-1:0] mode_i,
    input wire [`SMAC_GRP_W-1:0] group_i,
    input wire is_psw_upper_i,
    input wire is_protected_i,
    input wire is_random_out_i,
    input wire seg_rd_ok_i,
    input wire seg_wr_ok_i,
    output reg rd_ok_o,
    output reg wr_ok_o
);

    reg grp_rd;
    reg grp_wr;

    always @* begin
        grp_rd = 1'b0;
        grp_wr = 1'b0;
        case (group_i)
            `SMAC_GRP_CPU: begin
                grp_rd = 1'b1;
                grp_wr = 1'b1;
            end
            `SMAC_GRP_SEGCFG: begin
                // boot and test do not open this group either
                grp_rd = (mode_i == `SMAC_MODE_SYSTEM);
                grp_wr = (mode_i == `SMAC_MODE_SYSTEM);
            end
            `SMAC_GRP_SYSMGMT: begin
                grp_wr = (mode_i == `SMAC_MODE_BOOT) || (mode_i == `SMAC_MODE_TEST) ||
                         (mode_i == `SMAC_MODE_SYSTEM);
                grp_rd = grp_wr || (is_psw_upper_i && ((mode_i == `SMAC_MODE_LEGACY) ||
                                                       (mode_i == `SMAC_MODE_USER)));
            end
            `SMAC_GRP_HW: begin
                case (mode_i)
                    `SMAC_MODE_BOOT, `SMAC_MODE_TEST, `SMAC_MODE_LEGACY, `SMAC_MODE_SYSTEM: begin
                        grp_rd = 1'b1;
                        grp_wr = 1'b1;
                    end
                    `SMAC_MODE_USER: begin
                        grp_rd = seg_rd_ok_i;
                        grp_wr = seg_wr_ok_i;
                    end
                    default: begin
                        grp_rd = 1'b0;
                        grp_wr = 1'b0;
                    end
                endcase
            end
            default: begin
                grp_rd = 1'b0;
                grp_wr = 1'b0;
            end
        endcase
        rd_ok_o = grp_rd && !is_protected_i;
        wr_ok_o = grp_wr && !is_random_out_i;
    end

endmodule // smac_rule_eval
`default_nettype wire

// >>> hdl/smac_checker.v
// Purpose: gate every special function register access of the core by privilege mode
// Assumes: register groups answer reg_rdata_i combinationally for reg_addr_o
// Notes:   segment base and violation registers live inside this block
`default_nettype none
`include "smac_consts.vh"

// Notes on behaviour
// - boot mode opens cpu, system management and hardware groups, bar per-register exceptions.
// - test mode behaves exactly like boot mode.
// - legacy card mode opens only hardware and cpu groups.
// - system mode opens segmentation, system management and hardware groups.
// - user mode reaches hardware registers only as segment rights allow.
// - general cpu registers are open in every mode.
// - upper program status is also readable in legacy card and user modes.
// - segmentation configuration is refused outside system mode.
// - the three protected system registers never return their contents.
// - random value output ignores writes.
// - segment table base resets to zero, disabling all segments.
// - system mode code may rewrite the segment table base.
module smac_checker (
    input wire clk_i,
    input wire resetn_i,
    input wire [`SMAC_MODE_W-1:0] cpu_mode_i,
    input wire seg_rd_ok_i,
    input wire seg_wr_ok_i,
    input wire [7:0] acc_addr_i,
    input wire [7:0] acc_wdata_i,
    input wire acc_wr_i,
    input wire acc_rd_i,
    output reg [7:0] acc_rdata_o,
    output reg acc_denied_o,
    output wire [7:0] reg_addr_o,
    output wire [7:0] reg_wdata_o,
    output wire reg_wr_o,
    output wire reg_rd_o,
    input wire [7:0] reg_rdata_i,
    output wire [15:0] seg_table_base_o,
    output wire viol_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // classification and permission

    wire [`SMAC_GRP_W-1:0] group;
    wire is_psw_upper;
    wire is_protected;
    wire is_random_out;
    wire rd_ok;
    wire wr_ok;

    smac_group_decode u_decode (
        .addr_i(acc_addr_i),
        .group_o(group),
        .is_psw_upper_o(is_psw_upper),
        .is_protected_o(is_protected),
        .is_random_out_o(is_random_out)
    );

    smac_rule_eval u_eval (
        .mode_i(cpu_mode_i),
        .group_i(group),
        .is_psw_upper_i(is_psw_upper),
        .is_protected_i(is_protected),
        .is_random_out_i(is_random_out),
        .seg_rd_ok_i(seg_rd_ok_i),
        .seg_wr_ok_i(seg_wr_ok_i),
        .rd_ok_o(rd_ok),
        .wr_ok_o(wr_ok)
    );

    wire wr_go = acc_wr_i && wr_ok;
    wire rd_go = acc_rd_i && rd_ok;
    wire wr_deny = acc_wr_i && !wr_ok;
    wire rd_deny = acc_rd_i && !rd_ok;

    ////////////////////////////////////////////////////////////////////////////
    // local registers: segment table base and violation record

    wire hit_base_lo = (acc_addr_i == `SMAC_ADDR_SEG_BASE_LO);
    wire hit_base_hi = (acc_addr_i == `SMAC_ADDR_SEG_BASE_HI);
    wire hit_viol_st = (acc_addr_i == `SMAC_ADDR_VIOL_STATUS);
    wire hit_viol_ad = (acc_addr_i == `SMAC_ADDR_VIOL_ADDR);
    wire hit_local = hit_base_lo || hit_base_hi || hit_viol_st || hit_viol_ad;

    reg [7:0] base_lo_reg;
    reg [7:0] base_hi_reg;
    reg [1:0] viol_reg;
    reg [1:0] viol_next;
    reg [7:0] viol_addr_reg;

    // a zero base leaves every segment disabled until system code fills it in
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            base_lo_reg <= `SMAC_SEG_BASE_RST;
            base_hi_reg <= `SMAC_SEG_BASE_RST;
        end else begin
            if (wr_go && hit_base_lo) begin
                base_lo_reg <= acc_wdata_i;
            end
            if (wr_go && hit_base_hi) begin
                base_hi_reg <= acc_wdata_i;
            end
        end
    end

    assign seg_table_base_o = {base_hi_reg, base_lo_reg};

    // sticky record of refusals; software clears by writing ones, a new refusal wins
    always @* begin
        viol_next = viol_reg;
        if (wr_go && hit_viol_st) begin
            viol_next = viol_reg & ~acc_wdata_i[1:0];
        end
        if (wr_deny) begin
            viol_next[`SMAC_VIOL_WR_BIT] = 1'b1;
        end
        if (rd_deny) begin
            viol_next[`SMAC_VIOL_RD_BIT] = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            viol_reg <= 2'h0;
            viol_addr_reg <= `SMAC_VIOL_RST;
        end else begin
            viol_reg <= viol_next;
            if (wr_deny || rd_deny) begin
                viol_addr_reg <= acc_addr_i;
            end
        end
    end

    assign viol_flag_o = |viol_reg;

    ////////////////////////////////////////////////////////////////////////////
    // forwarding to the register groups

    // refused accesses never reach the group, so nothing is stored
    assign reg_addr_o = acc_addr_i;
    assign reg_wdata_o = acc_wdata_i;
    assign reg_wr_o = wr_go && !hit_local;
    assign reg_rd_o = rd_go && !hit_local;

    ////////////////////////////////////////////////////////////////////////////
    // read return, one cycle after the strobe

    reg [7:0] local_rdata;

    always @* begin
        local_rdata = 8'h00;
        if (hit_base_lo) begin
            local_rdata = base_lo_reg;
        end else if (hit_base_hi) begin
            local_rdata = base_hi_reg;
        end else if (hit_viol_st) begin
            local_rdata = {6'h00, viol_reg};
        end else if (hit_viol_ad) begin
            local_rdata = viol_addr_reg;
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            acc_rdata_o <= 8'h00;
            acc_denied_o <= 1'b0;
        end else begin
            acc_denied_o <= wr_deny || rd_deny;
            if (rd_go) begin
                acc_rdata_o <= hit_local ? local_rdata : reg_rdata_i;
            end else begin
                // denied reads and idle cycles show zero, never stale contents
                acc_rdata_o <= 8'h00;
            end
        end
    end

endmodule // smac_checker
`default_nettype wire

// >>> verification/smac_access_checker.sv
// Purpose: concurrent checks on the access decisions of smac_checker
// Assumes: one clock domain, synchronous active-low reset
// Notes: sees only top-level ports; attached by the bind at the foot
`default_nettype none
`include "smac_consts.vh"

module smac_access_sva (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] cpu_mode_i,
    input wire logic seg_rd_ok_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic acc_wr_i,
    input wire logic acc_rd_i,
    input wire logic [7:0] acc_rdata_o,
    input wire logic acc_denied_o,
    input wire logic reg_wr_o,
    input wire logic reg_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    wire strobe = acc_wr_i | acc_rd_i;
    wire in_cpu = acc_addr_i >= `SMAC_CPU_LO && acc_addr_i <= `SMAC_CPU_HI;
    wire in_seg = acc_addr_i >= `SMAC_SEGCFG_LO && acc_addr_i <= `SMAC_SEGCFG_HI;
    wire in_sys = acc_addr_i >= `SMAC_SYSMGMT_LO && acc_addr_i <= `SMAC_SYSMGMT_HI;
    wire in_hw = acc_addr_i >= `SMAC_HW_LO;
    wire prot = acc_addr_i >= `SMAC_ADDR_PROT_A && acc_addr_i <= `SMAC_ADDR_PROT_C;
    wire boot_test = cpu_mode_i == `SMAC_MODE_BOOT || cpu_mode_i == `SMAC_MODE_TEST;
    wire leg = cpu_mode_i == `SMAC_MODE_LEGACY;
    wire usr = cpu_mode_i == `SMAC_MODE_USER;
    wire psw_rd = acc_rd_i && acc_addr_i == `SMAC_ADDR_PSW_UPPER;

    ////////////////////////////////////////////////////////////////////////////
    // a refusal answers one cycle later with the pulse and empty data
    sequence s_refused;
        ##1 (acc_denied_o && acc_rdata_o == 8'h00);
    endsequence
    sequence s_granted;
        ##1 !acc_denied_o;
    endsequence

    property p_boot_sys;
        (boot_test && acc_wr_i && in_sys) |-> reg_wr_o ##0 s_granted;
    endproperty
    a_boot_sys: assert property (p_boot_sys) else $error("sysmgmt write refused in boot/test");
    property p_legacy_block;
        (leg && strobe && ((in_sys && !psw_rd) || in_seg)) |-> s_refused;
    endproperty
    a_legacy_block: assert property (p_legacy_block) else $error("legacy mode reached a closed group");
    property p_system_open;
        (cpu_mode_i == `SMAC_MODE_SYSTEM && acc_wr_i && (in_sys || in_hw) && acc_addr_i != `SMAC_ADDR_RANDOM_OUT)
            |-> reg_wr_o ##0 s_granted;
    endproperty
    a_system_open: assert property (p_system_open) else $error("system mode write refused");
    property p_user_hw;
        (usr && acc_rd_i && in_hw) |-> reg_rd_o == seg_rd_ok_i;
    endproperty
    a_user_hw: assert property (p_user_hw) else $error("user read ignores segment rights");
    property p_cpu_open;
        (strobe && in_cpu) |-> s_granted;
    endproperty
    a_cpu_open: assert property (p_cpu_open) else $error("cpu group access refused");
    property p_psw_read;
        ((leg || usr) && psw_rd) |-> reg_rd_o ##0 s_granted;
    endproperty
    a_psw_read: assert property (p_psw_read) else $error("upper status read refused");
    property p_seg_refuse;
        (strobe && in_seg && cpu_mode_i != `SMAC_MODE_SYSTEM) |-> s_refused;
    endproperty
    a_seg_refuse: assert property (p_seg_refuse) else $error("segcfg open outside system mode");
    property p_prot_read;
        (acc_rd_i && prot) |-> !reg_rd_o ##0 s_refused;
    endproperty
    a_prot_read: assert property (p_prot_read) else $error("protected register read through");
    property p_rand_ro;
        (acc_wr_i && acc_addr_i == `SMAC_ADDR_RANDOM_OUT) |-> !reg_wr_o ##1 acc_denied_o;
    endproperty
    a_rand_ro: assert property (p_rand_ro) else $error("random output accepted a write");
    property p_deny_quiet;
        acc_denied_o |-> acc_rdata_o == 8'h00 && !$past(reg_wr_o) && !$past(reg_rd_o);
    endproperty
    a_deny_quiet: assert property (p_deny_quiet) else $error("denied access reached a group");
endmodule // smac_access_sva

bind smac_checker smac_access_sva u_sva (.clk_i(clk_i), .resetn_i(resetn_i), .cpu_mode_i(cpu_mode_i),
    .seg_rd_ok_i(seg_rd_ok_i), .acc_addr_i(acc_addr_i), .acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i),
    .acc_rdata_o(acc_rdata_o), .acc_denied_o(acc_denied_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o));
`default_nettype wire

// >>> verification/smac_reg_groups_model.sv
// Purpose: behavioural register groups behind the checker
// Assumes: answers reg_rdata combinationally while reg_rd_i is high
// Notes: outside a read it shows inverted data so stale values never look right
`default_nettype none

module smac_reg_groups_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];

    // reset fills address xor A5, so a granted read is zero by chance only at address A5
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 256; i++) mem[i] <= 8'(i) ^ 8'hA5;
        end else if (reg_wr_i) begin
            mem[reg_addr_i] <= reg_wdata_i;
        end
    end
    assign reg_rdata_o = reg_rd_i ? mem[reg_addr_i] : ~mem[reg_addr_i];
endmodule // smac_reg_groups_model
`default_nettype wire

// >>> verification/tb_sfr_mode_access_control.sv
// Purpose: directed access sequences through every cpu mode
// Assumes: register groups model preloads address xor A5
// Notes: every access is a single strobe; answers sampled one cycle later
`default_nettype none
`include "smac_consts.vh"

module tb_sfr_mode_access_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, resetn_i = 1'b0, seg_rd = 1'b0, seg_wr = 1'b0, acc_wr = 1'b0, acc_rd = 1'b0, acc_denied_o;
    logic [2:0] mode = `SMAC_MODE_BOOT;
    logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, acc_rdata_o, reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, viol_flag_o;
    logic [15:0] seg_table_base_o;
    int error_cnt = 0, checks_done = 0;

    always #5 clk_i = ~clk_i;
    smac_checker u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cpu_mode_i(mode), .seg_rd_ok_i(seg_rd),
        .seg_wr_ok_i(seg_wr), .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata), .acc_wr_i(acc_wr), .acc_rd_i(acc_rd),
        .acc_rdata_o(acc_rdata_o), .acc_denied_o(acc_denied_o), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .seg_table_base_o(seg_table_base_o),
        .viol_flag_o(viol_flag_o));
    smac_reg_groups_model u_groups (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic set_mode(input logic [2:0] m, input logic r, input logic w);
        @(posedge clk_i);
        mode <= m;
        seg_rd <= r;
        seg_wr <= w;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic den);
        @(posedge clk_i);
        acc_addr <= a;
        acc_wdata <= d;
        acc_wr <= 1'b1;
        @(posedge clk_i);
        acc_wr <= 1'b0;
        #1;
        check(16'(acc_denied_o), 16'(den));
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic den);
        @(posedge clk_i);
        acc_addr <= a;
        acc_rd <= 1'b1;
        @(posedge clk_i);
        acc_rd <= 1'b0;
        #1;
        check(16'(acc_rdata_o), 16'(d));
        check(16'(acc_denied_o), 16'(den));
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard: the whole sequence needs far fewer cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1;
        check(seg_table_base_o, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            set_mode(i == 0 ? `SMAC_MODE_BOOT : `SMAC_MODE_TEST, 1'b0, 1'b0);
            wr(8'hB0, 8'h11, 1'b0);
            rd(8'hB0, 8'h11, 1'b0);
            wr(8'hC5, 8'h22, 1'b0);
            rd(8'hC5, 8'h22, 1'b0);
            rd(8'hA9, 8'h00, 1'b1);
            wr(8'hC0, 8'h77, 1'b1);
            rd(8'hC0, 8'h65, 1'b0);
            wr(8'hA0, 8'hFF, 1'b1);
        end
        check(16'(viol_flag_o), 16'h0001);
        rd(`SMAC_ADDR_VIOL_ADDR, 8'hA0, 1'b0);
        rd(`SMAC_ADDR_VIOL_STATUS, 8'h03, 1'b0);
        wr(`SMAC_ADDR_VIOL_STATUS, 8'h03, 1'b0);
        check(16'(viol_flag_o), 16'h0000);
        set_mode(`SMAC_MODE_SYSTEM, 1'b0, 1'b0);
        check(seg_table_base_o, 16'h0000);
        wr(8'hA0, 8'h5A, 1'b0);
        wr(8'hA1, 8'h3C, 1'b0);
        check(seg_table_base_o, 16'h3C5A);
        rd(8'hA0, 8'h5A, 1'b0);
        wr(8'hB0, 8'h33, 1'b0);
        rd(8'hB0, 8'h33, 1'b0);
        wr(8'hC5, 8'h44, 1'b0);
        rd(8'hAB, 8'h00, 1'b1);
        set_mode(`SMAC_MODE_LEGACY, 1'b0, 1'b0);
        rd(8'hA8, 8'h0D, 1'b0);
        wr(8'hB0, 8'h55, 1'b1);
        rd(8'hB0, 8'h00, 1'b1);
        rd(8'hA0, 8'h00, 1'b1);
        wr(8'hC5, 8'h66, 1'b0);
        rd(8'hC5, 8'h66, 1'b0);
        wr(8'h90, 8'h12, 1'b0);
        rd(8'h90, 8'h12, 1'b0);
        rd(8'h10, 8'h00, 1'b1);
        set_mode(`SMAC_MODE_USER, 1'b1, 1'b0);
        rd(8'hC5, 8'h66, 1'b0);
        wr(8'hC5, 8'h99, 1'b1);
        rd(8'hC5, 8'h66, 1'b0);
        rd(8'hA8, 8'h0D, 1'b0);
        rd(8'hB0, 8'h00, 1'b1);
        rd(8'h90, 8'h12, 1'b0);
        wr(8'hA1, 8'h00, 1'b1);
        check(seg_table_base_o, 16'h3C5A);
        set_mode(`SMAC_MODE_USER, 1'b0, 1'b1);
        rd(8'hC5, 8'h00, 1'b1);
        wr(8'hC5, 8'h99, 1'b0);
        set_mode(`SMAC_MODE_BOOT, 1'b0, 1'b0);
        rd(8'hC5, 8'h99, 1'b0);
        end_of_test();
    end
endmodule // tb_sfr_mode_access_control
`default_nettype wire
